// File: core/ofdvm_fast_detect.sv
/*
  One fast-detect channel: upper-threshold set, lower-threshold dwell clear.
  Assumes samples arrive once per clock with a two's-complement value.
*/
`timescale 1ns/1ps
`default_nettype none
module ofdvm_fast_detect #(
  parameter int SAMP_W = 14,
  parameter int THR_W = 13,
  parameter int DWELL_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [SAMP_W-1:0] sample,
  input wire logic [15:0] upper_thr,
  input wire logic [15:0] lower_thr,
  input wire logic [DWELL_W-1:0] dwell,
  output logic flag
);
  import ofdvm_pkg::*;

  // Refuse widths where the magnitude could not hold a full-scale value.
  if (SAMP_W < THR_W + 1 || DWELL_W < 1) begin : g_bad_widths
    $error("ofdvm_fast_detect: unsupported widths");
  end

  typedef struct packed {
    logic [SAMP_W-1:0] mag;
    logic flag;
    logic [DWELL_W-1:0] cnt;
  } ofdvm_fd_state_t;

  ofdvm_fd_state_t state;
  ofdvm_fd_state_t next_state;

  // --------------------------------------------------------------
  // Magnitude and hysteresis
  // --------------------------------------------------------------
  // Magnitude is registered once; this keeps the set path far inside
  // the allowed latency while easing timing of the compare.
  always_comb begin
    next_state = state;
    next_state.mag = sample[SAMP_W-1] ? SAMP_W'(-sample) : sample;
    if (state.mag > SAMP_W'(upper_thr[THR_W-1:0])) begin
      next_state.flag = 1'b1;
      next_state.cnt = '0;
    end else if (state.flag) begin
      if (state.mag >= SAMP_W'(lower_thr[THR_W-1:0])) begin
        next_state.cnt = '0;
      end else if (state.cnt >= dwell) begin
        next_state.flag = 1'b0;
        next_state.cnt = '0;
      end else begin
        next_state.cnt = state.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule
`default_nettype wire

// File: core/ofdvm_pkg.sv
/*
  Package for the overrange, fast-detect and virtual-converter mapper.
  Holds register offsets, field positions, mode codes and carrier structs.
  Assumes a byte-wide register port with a 16-bit address on the sample clock.
*/
package ofdvm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFDVM_CHIP_OPERATING_MODE = 16'h0200;
  localparam logic [15:0] OFDVM_CHIP_DECIMATION_RATIO = 16'h0201;
  localparam logic [15:0] OFDVM_UPPER_THRESHOLD_LOW = 16'h0247;
  localparam logic [15:0] OFDVM_UPPER_THRESHOLD_HIGH = 16'h0248;
  localparam logic [15:0] OFDVM_LOWER_THRESHOLD_LOW = 16'h0249;
  localparam logic [15:0] OFDVM_LOWER_THRESHOLD_HIGH = 16'h024a;
  localparam logic [15:0] OFDVM_DWELL_TIME_LOW = 16'h024b;
  localparam logic [15:0] OFDVM_DWELL_TIME_HIGH = 16'h024c;
  localparam logic [15:0] OFDVM_OVERRANGE_CLEAR = 16'h0562;
  localparam logic [15:0] OFDVM_OVERRANGE_STICKY_STATUS = 16'h0563;

  // ---------------------------------------------------------------
  // Field positions, widths and reset values
  // ---------------------------------------------------------------
  localparam int OFDVM_MODE_LSB = 0;
  localparam int OFDVM_MODE_W = 4;
  localparam int OFDVM_QIGN_BIT = 5;
  localparam int OFDVM_DEC_W = 4;
  localparam int OFDVM_THR_W = 13;
  localparam int OFDVM_SAMP_W = 14;
  localparam int OFDVM_NUM_VC = 8;
  localparam int OFDVM_NUM_DDC = 4;
  localparam logic [7:0] OFDVM_MODE_RST = 8'h00;
  localparam logic [7:0] OFDVM_DEC_RST = 8'h01;
  localparam logic [15:0] OFDVM_UPPER_RST = 16'h1fff;
  localparam logic [15:0] OFDVM_LOWER_RST = 16'h0000;
  localparam logic [15:0] OFDVM_DWELL_RST = 16'h0001;
  localparam logic [7:0] OFDVM_BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  localparam logic [3:0] OFDVM_MODE_FULL_BW = 4'h0;
  localparam logic [3:0] OFDVM_MODE_ONE_DDC = 4'h1;
  localparam logic [3:0] OFDVM_MODE_TWO_DDC = 4'h2;
  localparam logic [3:0] OFDVM_MODE_FOUR_DDC = 4'h3;

  // One converted sample with its overrange indicator.
  typedef struct packed {
    logic [OFDVM_SAMP_W-1:0] data;
    logic over;
  } ofdvm_samp_t;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ofdvm_req_t;

endpackage

// File: core/ofdvm_top.sv
/*
  Overrange monitor, fast detect and virtual-converter mapper.
  Assumes ADC and downconverter samples arrive on clk with valid strobes
  and that the register port is driven from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ofdvm_top #(
  parameter int DWELL_W = 16,
  parameter int PIPE_LAT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ofdvm_pkg::ofdvm_req_t req,
  output logic [7:0] rdata,
  input wire logic adc_valid,
  input wire logic signed [ofdvm_pkg::OFDVM_SAMP_W-1:0] adc_a,
  input wire logic signed [ofdvm_pkg::OFDVM_SAMP_W-1:0] adc_b,
  input wire logic adc_over_a,
  input wire logic adc_over_b,
  input wire logic ddc_valid,
  input wire logic [ofdvm_pkg::OFDVM_NUM_DDC-1:0][ofdvm_pkg::OFDVM_SAMP_W-1:0]
    ddc_i,
  input wire logic [ofdvm_pkg::OFDVM_NUM_DDC-1:0][ofdvm_pkg::OFDVM_SAMP_W-1:0]
    ddc_q,
  input wire logic [ofdvm_pkg::OFDVM_NUM_DDC-1:0] ddc_over,
  input wire logic [1:0] control_bits_per_sample,
  output logic threshold_flag_chan_a,
  output logic threshold_flag_chan_b,
  output ofdvm_pkg::ofdvm_samp_t [ofdvm_pkg::OFDVM_NUM_VC-1:0] vc_out,
  output logic [ofdvm_pkg::OFDVM_NUM_VC-1:0] vc_used,
  output logic vc_valid,
  output logic [3:0] vc_count
);
  import ofdvm_pkg::*;

  // the set path here is two registers deep, far under the limit.
  localparam int FD_LAT_MAX = 28;
  localparam int FD_LAT_USED = 2;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The dwell register pair is 16 bits wide, and the overrange delay
  // line shifts through a slice that needs at least two taps.
  if (DWELL_W != 16 || PIPE_LAT < 2 ||
      FD_LAT_USED > FD_LAT_MAX) begin : g_bad_params
    $error("ofdvm_top: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  // Everything this block remembers outside the two detectors lives in one
  // record, so the single clocked process below is the only place where that state can change.
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dec;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] dwell;
    logic [7:0] clr;
    logic [7:0] sticky;
    logic [7:0] rdata;
    logic [3:0] dec_cnt;
    logic [PIPE_LAT-1:0] over_a_pipe;
    logic [PIPE_LAT-1:0] over_b_pipe;
    ofdvm_samp_t [OFDVM_NUM_VC-1:0] vc;
    logic [OFDVM_NUM_VC-1:0] used;
    logic valid;
    logic [3:0] count;
  } ofdvm_state_t;

  ofdvm_state_t state;
  ofdvm_state_t next_state;

  logic [OFDVM_MODE_W-1:0] op_mode;
  logic q_ignore;
  logic [OFDVM_DEC_W-1:0] dec_ratio;
  logic over_a_aligned;
  logic over_b_aligned;
  logic csb_on;
  logic [OFDVM_NUM_VC-1:0] vc_over_now;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  // mode and Q-ignore fields.
  assign op_mode = state.mode[OFDVM_MODE_LSB +: OFDVM_MODE_W];
  assign q_ignore = state.mode[OFDVM_QIGN_BIT];
  assign dec_ratio = state.dec[OFDVM_DEC_W-1:0];
  // overrange delayed to match the sample pipeline.
  assign over_a_aligned = state.over_a_pipe[PIPE_LAT-1];
  assign over_b_aligned = state.over_b_pipe[PIPE_LAT-1];
  // control bit carried only when bits per sample nonzero.
  assign csb_on = control_bits_per_sample != 2'b00;

  // ---------------------------------------------------------------
  // Fast detect channels
  // ---------------------------------------------------------------
  // one detector per channel.
  // Both share one threshold and dwell set; each keeps its own magnitude
  // register and dwell counter, so one channel never holds the other.
  ofdvm_fast_detect #(
    .SAMP_W(OFDVM_SAMP_W),
    .THR_W(OFDVM_THR_W),
    .DWELL_W(DWELL_W)
  ) u_fd_a (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sample(adc_a),
    .upper_thr(state.upper),
    .lower_thr(state.lower),
    .dwell(state.dwell),
    .flag(threshold_flag_chan_a)
  );

  ofdvm_fast_detect #(
    .SAMP_W(OFDVM_SAMP_W),
    .THR_W(OFDVM_THR_W),
    .DWELL_W(DWELL_W)
  ) u_fd_b (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sample(adc_b),
    .upper_thr(state.upper),
    .lower_thr(state.lower),
    .dwell(state.dwell),
    .flag(threshold_flag_chan_b)
  );

  // ---------------------------------------------------------------
  // Register port, mapping and sticky status
  // ---------------------------------------------------------------
  // Registers, the overrange pipe, the mapper and the sticky bits share
  // one state record so every update sits in this single process.
  always_comb begin
    next_state = state;
    vc_over_now = '0;

    // Register writes. The status register is read only, so a write to
    // it falls into the default arm and is dropped.
    if (req.wr) begin
      unique case (req.addr)
        OFDVM_CHIP_OPERATING_MODE: next_state.mode = req.wdata;
        OFDVM_CHIP_DECIMATION_RATIO: next_state.dec = req.wdata;
        OFDVM_UPPER_THRESHOLD_LOW: next_state.upper[7:0] = req.wdata;
        OFDVM_UPPER_THRESHOLD_HIGH: next_state.upper[15:8] = req.wdata;
        OFDVM_LOWER_THRESHOLD_LOW: next_state.lower[7:0] = req.wdata;
        OFDVM_LOWER_THRESHOLD_HIGH: next_state.lower[15:8] = req.wdata;
        OFDVM_DWELL_TIME_LOW: next_state.dwell[7:0] = req.wdata;
        OFDVM_DWELL_TIME_HIGH: next_state.dwell[15:8] = req.wdata;
        OFDVM_OVERRANGE_CLEAR: next_state.clr = req.wdata;
        default: ;
      endcase
    end

    // Register reads return one cycle later; unmapped reads give zero.
    // The clear register reads back what software last wrote into it.
    if (req.rd) begin
      unique case (req.addr)
        OFDVM_CHIP_OPERATING_MODE: next_state.rdata = state.mode;
        OFDVM_CHIP_DECIMATION_RATIO: next_state.rdata = state.dec;
        OFDVM_UPPER_THRESHOLD_LOW: next_state.rdata = state.upper[7:0];
        OFDVM_UPPER_THRESHOLD_HIGH: next_state.rdata = state.upper[15:8];
        OFDVM_LOWER_THRESHOLD_LOW: next_state.rdata = state.lower[7:0];
        OFDVM_LOWER_THRESHOLD_HIGH: next_state.rdata = state.lower[15:8];
        OFDVM_DWELL_TIME_LOW: next_state.rdata = state.dwell[7:0];
        OFDVM_DWELL_TIME_HIGH: next_state.rdata = state.dwell[15:8];
        OFDVM_OVERRANGE_CLEAR: next_state.rdata = state.clr;
        OFDVM_OVERRANGE_STICKY_STATUS: next_state.rdata = state.sticky;
        default: next_state.rdata = OFDVM_BYTE_ZERO;
      endcase
    end

    // overrange delay line.
    // The raw flag is seen at the converter input, ahead of its sample,
    // so it waits PIPE_LAT cycles here to meet that sample.
    next_state.over_a_pipe = {state.over_a_pipe[PIPE_LAT-2:0], adc_over_a};
    next_state.over_b_pipe = {state.over_b_pipe[PIPE_LAT-2:0], adc_over_b};

    // decimation counter in full band mode.
    next_state.valid = 1'b0;
    next_state.vc = '0;
    next_state.used = '0;
    next_state.count = 4'h0;
    unique case (op_mode)
      // channel A on converter 0, B on 1.
      OFDVM_MODE_FULL_BW: begin
        next_state.count = 4'h2;
        next_state.used = 8'h03;
        next_state.vc[0].data = adc_a;
        next_state.vc[1].data = adc_b;
        vc_over_now[0] = over_a_aligned;
        vc_over_now[1] = over_b_aligned;
        // A ratio of zero or one passes every sample; otherwise the
        // counter wraps at the ratio, so strobes are exactly that far apart.
        if (adc_valid) begin
          if (state.dec_cnt + 4'h1 >= dec_ratio) begin
            next_state.dec_cnt = 4'h0;
            next_state.valid = 1'b1;
          end else begin
            next_state.dec_cnt = state.dec_cnt + 4'h1;
          end
        end
      end
      // downconverter modes; pair I then Q.
      OFDVM_MODE_ONE_DDC, OFDVM_MODE_TWO_DDC, OFDVM_MODE_FOUR_DDC: begin
        // The downconverters already decimate, so their strobe is used.
        // Real output packs one slot per downconverter; complex output
        // takes two, which is why all eight slots need four complex ones.
        next_state.valid = ddc_valid;
        for (int d = 0; d < OFDVM_NUM_DDC; d++) begin
          if (d < (op_mode == OFDVM_MODE_FOUR_DDC ? 4 : int'(op_mode))) begin
            if (q_ignore) begin
              next_state.vc[d].data = ddc_i[d];
              next_state.used[d] = 1'b1;
              vc_over_now[d] = ddc_over[d];
            end else begin
              // all eight only in four complex mode.
              next_state.vc[2*d].data = ddc_i[d];
              next_state.vc[2*d+1].data = ddc_q[d];
              next_state.used[2*d] = 1'b1;
              next_state.used[2*d+1] = 1'b1;
              vc_over_now[2*d] = ddc_over[d];
              vc_over_now[2*d+1] = ddc_over[d];
            end
          end
        end
        next_state.count = 4'(
          (op_mode == OFDVM_MODE_FOUR_DDC ? 4 : int'(op_mode)) *
          (q_ignore ? 1 : 2));
      end
      default: ;
    endcase

    // overrange bit embedded only when control bits enabled.
    for (int v = 0; v < OFDVM_NUM_VC; v++) begin
      next_state.vc[v].over = csb_on & vc_over_now[v];
    end

    // sticky bits; clear held high, a new event wins.
    // While a clear bit stays at one its status bit only follows live
    // events, so software must return the clear bit to zero afterwards.
    next_state.sticky = (state.sticky & ~state.clr) | vc_over_now;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // The reset branch loads constants only; a low ce holds every field,
  // the register bank included.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.mode <= OFDVM_MODE_RST;
      state.dec <= OFDVM_DEC_RST;
      state.upper <= OFDVM_UPPER_RST;
      state.lower <= OFDVM_LOWER_RST;
      state.dwell <= OFDVM_DWELL_RST;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a direct view of a flip-flop, so the link side sees
  // no combinational path from the register port.
  assign rdata = state.rdata;
  assign vc_out = state.vc;
  assign vc_used = state.used;
  assign vc_valid = state.valid;
  assign vc_count = state.count;

endmodule
`default_nettype wire

// File: testbench/ofdvm_assertions.sv
/*
  Checker for the mapper top: fast-detect, register and mapping relations.
  Assumes ce drops only while nothing it watches moves, and that it is
  bound from the testbench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module ofdvm_assertions import ofdvm_pkg::*; #(
  parameter int DWELL_W = 16,
  parameter int PIPE_LAT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire ofdvm_pkg::ofdvm_req_t req,
  input wire logic [7:0] rdata,
  input wire logic signed [ofdvm_pkg::OFDVM_SAMP_W-1:0] adc_a,
  input wire logic [1:0] control_bits_per_sample,
  input wire logic threshold_flag_chan_a,
  input wire ofdvm_pkg::ofdvm_samp_t [ofdvm_pkg::OFDVM_NUM_VC-1:0] vc_out,
  input wire logic [ofdvm_pkg::OFDVM_NUM_VC-1:0] vc_used,
  input wire logic [3:0] vc_count
);
  logic [15:0] up;
  logic [15:0] lo;
  logic [13:0] mag;
  logic over;
  logic below;
  logic unused_nz;
  logic over_any;

  // Magnitude of channel A and its threshold relations.
  assign mag = adc_a[13] ? 14'(-adc_a) : adc_a;
  assign over = mag > {1'b0, up[12:0]};
  assign below = mag < {1'b0, lo[12:0]};

  // Shadow thresholds track writes so the flag timing can be judged.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up <= OFDVM_UPPER_RST;
      lo <= OFDVM_LOWER_RST;
    end else if (req.wr) begin
      if (req.addr == OFDVM_UPPER_THRESHOLD_LOW) up[7:0] <= req.wdata;
      if (req.addr == OFDVM_UPPER_THRESHOLD_HIGH) up[15:8] <= req.wdata;
      if (req.addr == OFDVM_LOWER_THRESHOLD_LOW) lo[7:0] <= req.wdata;
      if (req.addr == OFDVM_LOWER_THRESHOLD_HIGH) lo[15:8] <= req.wdata;
    end
  end

  // Unused slots must be empty; over_any gathers every embedded over bit.
  always_comb begin
    unused_nz = 1'b0;
    over_any = 1'b0;
    for (int i = 0; i < OFDVM_NUM_VC; i++) begin
      if (!vc_used[i] && vc_out[i] != '0) unused_nz = 1'b1;
      if (vc_out[i].over) over_any = 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_over_seen;
    over;
  endsequence
  sequence s_two_below;
    $past(below, 3) ##0 $past(below, 2);
  endsequence

  a_flag_sets: assert property (s_over_seen |-> ##2 threshold_flag_chan_a)
    else $error("flag late after upper crossing");
  a_flag_cause: assert property ($rose(threshold_flag_chan_a) |-> $past(over, 2))
    else $error("flag rose without a crossing");
  a_flag_clears: assert property ($fell(threshold_flag_chan_a) |-> s_two_below)
    else $error("flag cleared without low samples");
  a_read_upper: assert property (req.rd && req.addr == OFDVM_UPPER_THRESHOLD_LOW
    |=> rdata == up[7:0]) else $error("upper threshold readback wrong");
  a_read_unmapped: assert property (req.rd && req.addr < 16'h0200
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_count_used: assert property (vc_count == 4'($countones(vc_used)))
    else $error("count and used mask disagree");
  a_used_ascend: assert property (((vc_used + 8'h01) & vc_used) == 8'h00)
    else $error("used converters not packed low");
  a_unused_zero: assert property (!unused_nz)
    else $error("unused converter carries data");
  // control bit gate: the slot register follows the setting a cycle late.
  a_over_gated: assert property (control_bits_per_sample == 2'b00
    |=> !over_any) else $error("overrange bit sent without control bits");
endmodule
`default_nettype wire

// File: testbench/ofdvm_link_sink.sv
/*
  Receiving-side model: captures each mapped frame on vc_valid.
  Assumes the mapper presents a whole frame in the cycle of its strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module ofdvm_link_sink import ofdvm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic vc_valid,
  input wire ofdvm_pkg::ofdvm_samp_t [ofdvm_pkg::OFDVM_NUM_VC-1:0] vc_out,
  output var ofdvm_pkg::ofdvm_samp_t [ofdvm_pkg::OFDVM_NUM_VC-1:0] frame,
  output var logic [15:0] frames
);
  // The strobe lasts one cycle, so a late sample would lose the frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame <= '0;
      frames <= 16'h0000;
    end else if (vc_valid) begin
      frame <= vc_out;
      frames <= frames + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the mapper top with a link-side sink model.
  Assumes one 25 MHz clock; ce drops only in the decimation test.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ofdvm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, adc_valid = 1'b1, ddc_valid = 1'b1;
  ofdvm_req_t req = '0;
  logic signed [13:0] adc_a = 14'sh0111, adc_b = 14'sh0222;
  logic adc_over_a = 1'b0, adc_over_b = 1'b0;
  logic [3:0][13:0] ddc_i = {14'h0103, 14'h0102, 14'h0101, 14'h0100};
  logic [3:0][13:0] ddc_q = {14'h0203, 14'h0202, 14'h0201, 14'h0200};
  logic [3:0] ddc_over = 4'h0;
  logic [1:0] control_bits_per_sample = 2'b00;
  logic threshold_flag_chan_a, threshold_flag_chan_b, vc_valid;
  logic [7:0] rdata, vc_used, d;
  logic [3:0] vc_count;
  ofdvm_samp_t [7:0] vc_out, frame;
  logic [15:0] frames, f0;
  int errors = 0, check_count = 0, n;

  always #20 clk = ~clk;

  ofdvm_top #(.DWELL_W(16), .PIPE_LAT(4)) uut (.clk(clk), .rst(rst), .ce(ce),
    .req(req), .rdata(rdata), .adc_valid(adc_valid), .adc_a(adc_a),
    .adc_b(adc_b), .adc_over_a(adc_over_a), .adc_over_b(adc_over_b),
    .ddc_valid(ddc_valid), .ddc_i(ddc_i), .ddc_q(ddc_q), .ddc_over(ddc_over),
    .control_bits_per_sample(control_bits_per_sample),
    .threshold_flag_chan_a(threshold_flag_chan_a),
    .threshold_flag_chan_b(threshold_flag_chan_b), .vc_out(vc_out),
    .vc_used(vc_used), .vc_valid(vc_valid), .vc_count(vc_count));
  ofdvm_link_sink sink (.clk(clk), .rst(rst), .vc_valid(vc_valid),
    .vc_out(vc_out), .frame(frame), .frames(frames));

  // ---------------------------------------------------------------
  // Bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, v};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 req = '0;
    v = rdata;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd(OFDVM_CHIP_DECIMATION_RATIO, d); check(d, 8'h01);
    rd(OFDVM_UPPER_THRESHOLD_HIGH, d); check(d, 8'h1f);
    rd(OFDVM_UPPER_THRESHOLD_LOW, d); check(d, 8'hff);
    rd(OFDVM_DWELL_TIME_LOW, d); check(d, 8'h01);
    rd(16'h0100, d); check(d, 8'h00);
    wr(OFDVM_OVERRANGE_STICKY_STATUS, 8'hff);
    rd(OFDVM_OVERRANGE_STICKY_STATUS, d); check(d, 8'h00);
    $display("register test done");
  endtask
  task automatic t_fast();
    wr(OFDVM_UPPER_THRESHOLD_LOW, 8'hff);
    wr(OFDVM_UPPER_THRESHOLD_HIGH, 8'h0f);
    wr(OFDVM_LOWER_THRESHOLD_LOW, 8'h1d);
    wr(OFDVM_LOWER_THRESHOLD_HIGH, 8'h0a);
    wr(OFDVM_DWELL_TIME_LOW, 8'h03);
    adc_a = 14'sh0fff;
    step(1);
    adc_a = 14'sh0100;
    step(3); check(threshold_flag_chan_a, 1'b0);
    adc_a = -14'sh1000;
    step(1);
    adc_a = 14'sh0100;
    step(2); check(threshold_flag_chan_a, 1'b1);
    check(threshold_flag_chan_b, 1'b0);
    adc_a = 14'sh0a1d;
    step(1);
    adc_a = 14'sh0100;
    step(4); check(threshold_flag_chan_a, 1'b1);
    step(6); check(threshold_flag_chan_a, 1'b0);
    adc_b = -14'sh1000;
    step(1);
    adc_b = 14'sh0222;
    step(2); check(threshold_flag_chan_b, 1'b1);
    check(threshold_flag_chan_a, 1'b0);
    adc_a = 14'sh0111;
    $display("fast detect test done");
  endtask
  task automatic t_map();
    for (int m = 0; m < 5; m++) begin
      for (int q = 0; q < 2; q++) begin
        wr(OFDVM_CHIP_OPERATING_MODE, 8'(m | (q << 5)));
        step(3);
        n = (m == 0) ? 2 : (m == 4) ? 0 : ((m == 3) ? 4 : m) << (1 - q);
        check(vc_count, n);
        check(vc_used, (1 << n) - 1);
        for (int s = 0; s < n; s++) begin
          if (m == 0) check(frame[s].data, s ? adc_b : adc_a);
          else if (q) check(frame[s].data, ddc_i[s]);
          else check(frame[s].data, s[0] ? ddc_q[s/2] : ddc_i[s/2]);
        end
      end
    end
    $display("mapping test done");
  endtask
  task automatic t_sticky();
    wr(OFDVM_CHIP_OPERATING_MODE, 8'h03);
    control_bits_per_sample = 2'b01;
    ddc_over = 4'b0100;
    step(3); check({vc_out[5].over, vc_out[4].over, vc_out[0].over}, 3'b110);
    ddc_over = 4'b0000;
    step(3);
    control_bits_per_sample = 2'b00;
    ddc_over = 4'b0001;
    step(3); check(vc_out[0].over, 1'b0);
    ddc_over = 4'b0000;
    rd(OFDVM_OVERRANGE_STICKY_STATUS, d); check(d, 8'h33);
    wr(OFDVM_OVERRANGE_CLEAR, 8'h30);
    wr(OFDVM_OVERRANGE_CLEAR, 8'h00);
    rd(OFDVM_OVERRANGE_STICKY_STATUS, d); check(d, 8'h03);
    wr(OFDVM_OVERRANGE_CLEAR, 8'hff);
    wr(OFDVM_OVERRANGE_CLEAR, 8'h00);
    wr(OFDVM_CHIP_OPERATING_MODE, 8'h00);
    adc_over_a = 1'b1;
    step(1);
    adc_over_a = 1'b0;
    step(8);
    rd(OFDVM_OVERRANGE_STICKY_STATUS, d); check(d, 8'h01);
    $display("sticky test done");
  endtask
  task automatic t_dec();
    wr(OFDVM_CHIP_DECIMATION_RATIO, 8'h04);
    step(4);
    f0 = frames;
    step(40); check(frames - f0, 16'd10);
    wr(OFDVM_CHIP_DECIMATION_RATIO, 8'h01);
    ce = 1'b0;
    wr(OFDVM_CHIP_OPERATING_MODE, 8'h04);
    ce = 1'b1;
    rd(OFDVM_CHIP_OPERATING_MODE, d); check(d, 8'h00);
    check(vc_count, 4'h2);
    $display("decimation test done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence after the 16-cycle reset.
  initial begin
    step(16);
    rst = 1'b0;
    t_regs();
    t_fast();
    t_map();
    t_sticky();
    t_dec();
    stop_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule

bind ofdvm_top ofdvm_assertions #(.DWELL_W(DWELL_W), .PIPE_LAT(PIPE_LAT))
  chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .adc_a(adc_a),
  .control_bits_per_sample(control_bits_per_sample),
  .threshold_flag_chan_a(threshold_flag_chan_a), .vc_out(vc_out),
  .vc_used(vc_used), .vc_count(vc_count));
`default_nettype wire
